/* File: hdl/ssp_cfg.svh */
// Purpose: register map, field positions, reset values and rate counts
// Assumes: 32-bit apb data, one aligned word per register
// Notes:   definitions only
`ifndef SSP_CFG_SVH
`define SSP_CFG_SVH
`define SSP_ADDR_STAT  8'h00
`define SSP_ADDR_CON1  8'h04
`define SSP_ADDR_BUF   8'h08
`define SSP_STAT_SMP   7
`define SSP_STAT_CKE   6
`define SSP_STAT_BF    0
`define SSP_CON_WRITE_COLLISION   7
`define SSP_CON_OVF    6
`define SSP_CON_EN     5
`define SSP_CON_CKP    4
`define SSP_CON_RST    8'h00
`define SSP_STAT_RST   2'h0
`define SSP_HALF_DIV4  6'h02
`define SSP_HALF_DIV16 6'h08
`define SSP_HALF_DIV64 6'h20
`define SSP_EDGE_LAST  5'h10
`define SSP_EDGE_LATE  5'h11
`define SSP_BIT_LAST   3'h7
`endif

/* File: hdl/ssp_pkg.sv */
// Purpose: shared types of the serial port
// Assumes: constants live in ssp_cfg.svh
// Notes:   mode codes are the 4-bit mode_select_field values
package ssp_pkg;
    typedef enum logic [3:0] {
        SSP_M_DIV4  = 4'h0,  // master, clk/4
        SSP_M_DIV16 = 4'h1,  // master, clk/16
        SSP_M_DIV64 = 4'h2,  // master, clk/64
        SSP_M_TIMER_TWO  = 4'h3,  // master, timer_two output/2
        SSP_S_SSEN  = 4'h4,  // slave, select honoured
        SSP_S_NOSS  = 4'h5   // slave, select ignored
    } ssp_mode_t;
    typedef enum logic [1:0] {
        SSP_R_DIV4  = 2'b00,
        SSP_R_DIV16 = 2'b01,
        SSP_R_DIV64 = 2'b10,
        SSP_R_TIMER_TWO  = 2'b11
    } ssp_rate_t;
    typedef enum logic {
        SSP_IDLE = 1'b0,     // master waiting for a buffer write
        SSP_RUN  = 1'b1      // master clocking a byte
    } ssp_state_t;
endpackage

/* File: hdl/ssp_rate_if.sv */
// Purpose: link between the port core and its bit-rate divider
// Assumes: both ends on clk
// Notes:   tick is a one-cycle enable, one per half serial period
interface ssp_rate_if;
    logic               run;      // divider counting
    ssp_pkg::ssp_rate_t rateSel;  // selected rate
    logic               t2Pulse;  // timer_two output pulse
    logic               tick;     // half-period enable
    modport gen  (input run, rateSel, t2Pulse, output tick);
    modport core (output run, rateSel, t2Pulse, input tick);
endinterface

/* File: hdl/ssp_rate_gen.sv */
// Purpose: half-period enable for the master serial clock
// Assumes: clk is the oscillator; timer_two pulses are on clk
// Notes:   counter restarts whenever the master is not running
module ssp_rate_gen #(
    parameter int CW = 6          // counter width
) (
    input wire logic clk,         // core clock
    input wire logic rst,         // sync reset, active high
    ssp_rate_if.gen  rif          // rate request and tick
);
`include "ssp_cfg.svh"
    logic [CW-1:0] cnt_reg;       // cycles since last tick
    logic [CW-1:0] halfCnt;       // cycles per half period
    logic          cntHit;        // divider reached its count

    // half period per rate: full period is 4, 16 or 64 clocks
    always_comb begin
        unique case (rif.rateSel)
            ssp_pkg::SSP_R_DIV4:  halfCnt = CW'(`SSP_HALF_DIV4);
            ssp_pkg::SSP_R_DIV16: halfCnt = CW'(`SSP_HALF_DIV16);
            ssp_pkg::SSP_R_DIV64: halfCnt = CW'(`SSP_HALF_DIV64);
            ssp_pkg::SSP_R_TIMER_TWO:  halfCnt = CW'(`SSP_HALF_DIV4);
        endcase
    end

    assign cntHit = (cnt_reg == halfCnt - CW'(1));

    // each timer_two pulse toggles the clock, two pulses a period
    assign rif.tick = rif.run && ((rif.rateSel == ssp_pkg::SSP_R_TIMER_TWO)
                      ? rif.t2Pulse : cntHit);

    // free count while running, cleared on each tick
    always_ff @(posedge clk) begin
        if (rst || !rif.run || rif.tick) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_reg + CW'(1);
        end
    end
endmodule

/* File: hdl/ssp_spi_top.sv */
// Purpose: byte serial port in spi mode, master or slave, apb registers
// Assumes: clk is the oscillator; pins are synchronised here
// Notes:   zero-wait apb slave; serial clock pin sampled, not a clock
// Functional notes
// - full byte moves to buffer, flags set
// - buffer write loads buffer and shifter
// - master sample at middle or end
// - clock edge bit picks output edge
// - buffer_full set on byte, cleared on read
// - write during shifting dropped, collision flagged
// - slave overflow keeps old byte, flags
// - enable hands pins to port
// - clock_idle_level sets serial clock idle
// - codes 0101 and 0100 select slave
// - codes 0000 to 0011 select master rate
// - shifting is most significant bit first
// - status upper two bits writable only
// - shifter reached only through the buffer
// - data-in direction automatic, others software; here the port sets the clock and data-out enables itself
// - shift one edge, latch opposite edge
// - master starts on buffer write
// - port reset clears count, releases data-out
//
// Design decisions made here: the register offsets and the APB register port.
module ssp_spi_top (
    input  wire logic        clk,           // core clock, 50 MHz
    input  wire logic        rst,           // sync reset, active high
    input  wire logic        psel,          // apb select
    input  wire logic        penable,       // apb access phase
    input  wire logic        pwrite,        // apb direction
    input  wire logic [7:0]  paddr,         // apb byte address
    input  wire logic [31:0] pwdata,        // apb write data
    output logic      [31:0] prdata,        // apb read data
    output logic             pready,        // apb ready
    output logic             pslverr,       // apb unmapped address
    input  wire logic        sckIn,         // serial clock pin level
    output logic             sckOut,        // serial clock drive
    output logic             sckOe,         // serial clock enable
    output logic             sdoOut,        // data-out drive
    output logic             sdoOe,         // data-out enable
    input  wire logic        sdiIn,         // data-in pin level
    input  wire logic        ssInN,         // slave select, low active
    input  wire logic        timerTwoPulse, // timer_two output pulse
    output logic             portIrqFlag,   // one-cycle byte event
    output logic             portPinsOwned  // pins given to port
);
`include "ssp_cfg.svh"
    ssp_rate_if rif ();                     // divider link

    // synchronisers: stage 0 is read only by stage 1
    logic [1:0] sckSy_reg;                  // serial clock pin
    logic [1:0] sdiSy_reg;                  // data-in pin
    logic [1:0] ssSy_reg;                   // slave select pin
    logic       sckPrev_reg;                // last synced clock
    logic       sckS;                       // synced clock level
    logic       sdiS;                       // synced data-in
    logic       ssS;                        // synced select, high idle

    // software-visible state
    logic       write_collision_reg;                   // write_collision
    logic       ovf_reg;                    // receive_overflow
    logic       en_reg;                     // port_enable
    logic       ckp_reg;                    // clock_idle_level
    logic [3:0] mode_reg;                   // mode_select_field
    logic       smp_reg;                    // sample_phase
    logic       cke_reg;                    // output edge select
    logic       bufFull_reg;                // buffer_full
    logic [7:0] hold_reg;                   // rx_tx_holding_reg

    // shifter, hidden from software, split into its two halves
    logic [7:0] txSh_reg;                   // outgoing bits
    logic [7:0] rxSh_reg;                   // incoming bits
    logic       txBit_reg;                  // bit on data-out
    logic [7:0] rxByte;                     // byte as completed

    // sequencing
    ssp_pkg::ssp_state_t state_reg;         // master state
    logic [4:0] edgeCnt_reg;                // master edges so far
    logic [4:0] nEdge;                      // edge number of a tick
    logic [2:0] bitCnt_reg;                 // slave bits latched
    logic       sckOut_reg;                 // master clock level
    logic       irq_reg;                    // port_irq_flag pulse
    logic [31:0] prdata_reg;                // read data
    logic       pslverr_reg;                // error answer

    // decoded controls
    logic isMaster, isSlave, ssCtl, ssHigh, isRun;
    logic apbWr, apbRd, statWr, conWr, bufWr, bufRd;
    logic busy, loadOk, collide;
    logic lead, trail, mOut, mIn, mTx, mSample, mTick, mDone;
    logic sckEdge, sLead, sTrail, sOut, sIn, sDone, sActive;
    logic rxShift, rxDone;

    // true for the three word addresses of the map
    function automatic logic mapped(input logic [7:0] a);
        return (a == `SSP_ADDR_STAT) || (a == `SSP_ADDR_CON1) ||
               (a == `SSP_ADDR_BUF);
    endfunction

    // pins come from another domain, two flops before use
    always_ff @(posedge clk) begin
        if (rst) begin
            sckSy_reg   <= 2'h0;
            sdiSy_reg   <= 2'h0;
            ssSy_reg    <= 2'h3;
            sckPrev_reg <= 1'h0;
        end else begin
            sckSy_reg   <= {sckSy_reg[0], sckIn};
            sdiSy_reg   <= {sdiSy_reg[0], sdiIn};
            ssSy_reg    <= {ssSy_reg[0], ssInN};
            sckPrev_reg <= sckSy_reg[1];
        end
    end
    assign sckS = sckSy_reg[1];
    assign sdiS = sdiSy_reg[1];
    assign ssS  = ssSy_reg[1];

    // mode decode; unlisted codes run neither side
    assign isMaster = (mode_reg[3:2] == 2'b00);
    assign isSlave  = (mode_reg == ssp_pkg::SSP_S_SSEN) ||
                      (mode_reg == ssp_pkg::SSP_S_NOSS);
    assign ssCtl    = (mode_reg == ssp_pkg::SSP_S_SSEN);
    assign ssHigh   = ssCtl && ssS;
    assign isRun    = (state_reg == ssp_pkg::SSP_RUN);

    // apb decode, effects land at the access edge
    assign apbWr  = psel && penable && pwrite;
    assign apbRd  = psel && penable && !pwrite;
    assign statWr = apbWr && (paddr == `SSP_ADDR_STAT);
    assign conWr  = apbWr && (paddr == `SSP_ADDR_CON1);
    assign bufWr  = apbWr && (paddr == `SSP_ADDR_BUF);
    assign bufRd  = apbRd && (paddr == `SSP_ADDR_BUF);

    // a byte on the wire makes the buffer unwritable
    assign busy    = isRun || (isSlave && (bitCnt_reg != 3'h0));
    assign loadOk  = bufWr && en_reg && !busy;
    assign collide = bufWr && busy;

    // divider request
    assign rif.run     = isRun;
    assign rif.rateSel = ssp_pkg::ssp_rate_t'(mode_reg[1:0]);
    assign rif.t2Pulse = timerTwoPulse;

    ssp_rate_gen #(.CW(6)) u_rate (
        .clk (clk),
        .rst (rst),
        .rif (rif)
    );

    // master edges: odd numbers leave idle, even return to it
    assign mTick   = isRun && rif.tick;
    assign nEdge   = edgeCnt_reg + 5'h01;
    assign lead    = nEdge[0] && (nEdge < `SSP_EDGE_LAST);
    assign trail   = !nEdge[0] && (nEdge <= `SSP_EDGE_LAST);
    assign mOut    = cke_reg ? trail : lead;
    assign mIn     = cke_reg ? lead : trail;
    assign mTx     = mOut && (nEdge < `SSP_EDGE_LAST);
    // late sampling waits for the next output edge; with
    // leading-edge output the last bit needs one extra half period
    assign mSample = smp_reg ? ((cke_reg && trail) ||
                     (!cke_reg && ((lead && nEdge > 5'h02) ||
                     nEdge == `SSP_EDGE_LATE))) : mIn;
    assign mDone   = mTick && (nEdge == ((smp_reg && !cke_reg)
                     ? `SSP_EDGE_LATE : `SSP_EDGE_LAST));

    // slave edges seen on the synced pin against the idle level
    assign sActive = en_reg && isSlave && !ssHigh;
    assign sckEdge = sActive && (sckS != sckPrev_reg);
    assign sLead   = sckEdge && (sckPrev_reg == ckp_reg);
    assign sTrail  = sckEdge && (sckS == ckp_reg);
    assign sOut    = cke_reg ? sTrail : sLead;
    assign sIn     = cke_reg ? sLead : sTrail;
    assign sDone   = sIn && (bitCnt_reg == `SSP_BIT_LAST);

    assign rxShift = (mTick && mSample) || sIn;
    assign rxDone  = mDone || sDone;
    assign rxByte  = rxShift ? {rxSh_reg[6:0], sdiS} : rxSh_reg;

    // master sequencer, started by the buffer write
    always_ff @(posedge clk) begin
        if (rst || !en_reg) begin
            state_reg   <= ssp_pkg::SSP_IDLE;
            edgeCnt_reg <= 5'h00;
        end else begin
            unique case (state_reg)
                ssp_pkg::SSP_IDLE: begin
                    edgeCnt_reg <= 5'h00;
                    if (loadOk && isMaster) begin
                        state_reg <= ssp_pkg::SSP_RUN;
                    end
                end
                ssp_pkg::SSP_RUN: begin
                    if (mDone) begin
                        state_reg <= ssp_pkg::SSP_IDLE;
                    end else if (rif.tick) begin
                        edgeCnt_reg <= nEdge;
                    end
                end
            endcase
        end
    end

    // master clock level: idle level until an edge is due
    always_ff @(posedge clk) begin
        if (rst) begin
            sckOut_reg <= 1'h0;
        end else if (!isRun) begin
            sckOut_reg <= ckp_reg;
        end else if (rif.tick && (lead || trail)) begin
            sckOut_reg <= !sckOut_reg;
        end
    end

    // slave bit count, cleared whenever the port resets
    always_ff @(posedge clk) begin
        if (rst || !en_reg || !isSlave || ssHigh) begin
            bitCnt_reg <= 3'h0;
        end else if (sIn) begin
            bitCnt_reg <= bitCnt_reg + 3'h1;
        end
    end

    // transmit half: loaded from the buffer write only
    always_ff @(posedge clk) begin
        if (rst) begin
            txSh_reg  <= 8'h00;
            txBit_reg <= 1'h0;
        end else if (loadOk) begin
            // early output edge: first bit shows before any clock
            txBit_reg <= pwdata[7];
            txSh_reg  <= cke_reg ? {pwdata[6:0], 1'b0}
                                 : pwdata[7:0];
        end else if ((mTick && mTx) || sOut) begin
            txBit_reg <= txSh_reg[7];
            txSh_reg  <= {txSh_reg[6:0], 1'b0};
        end
    end

    // receive half, msb arrives first
    always_ff @(posedge clk) begin
        if (rst || loadOk) begin
            rxSh_reg <= 8'h00;
        end else if (rxShift) begin
            rxSh_reg <= rxByte;
        end
    end

    // holding register: byte in from the wire or from software
    always_ff @(posedge clk) begin
        if (rst) begin
            hold_reg <= 8'h00;
        end else if (loadOk) begin
            hold_reg <= pwdata[7:0];
        end else if (mDone || (sDone && !bufFull_reg)) begin
            hold_reg <= rxByte;
        end
    end

    // buffer_full: a new byte wins over a read in the same cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            bufFull_reg <= 1'h0;
        end else if (rxDone) begin
            bufFull_reg <= 1'h1;
        end else if (bufRd) begin
            bufFull_reg <= 1'h0;
        end
    end

    // byte event pulse, also raised on an overflowed byte
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_reg <= 1'h0;
        end else begin
            irq_reg <= rxDone;
        end
    end

    // control register; hardware sets of the flags beat writes
    always_ff @(posedge clk) begin
        if (rst) begin
            {write_collision_reg, ovf_reg, en_reg, ckp_reg, mode_reg} <= `SSP_CON_RST;
        end else begin
            if (conWr) begin
                en_reg   <= pwdata[`SSP_CON_EN];
                ckp_reg  <= pwdata[`SSP_CON_CKP];
                mode_reg <= pwdata[3:0];
            end
            if (collide) begin
                write_collision_reg <= 1'h1;
            end else if (conWr) begin
                write_collision_reg <= pwdata[`SSP_CON_WRITE_COLLISION];
            end
            // only a slave can overrun; a master byte is always asked for
            if (sDone && bufFull_reg) begin
                ovf_reg <= 1'h1;
            end else if (conWr) begin
                ovf_reg <= pwdata[`SSP_CON_OVF];
            end
        end
    end

    // status register: only the two phase bits take writes
    always_ff @(posedge clk) begin
        if (rst) begin
            {smp_reg, cke_reg} <= `SSP_STAT_RST;
        end else if (statWr) begin
            smp_reg <= pwdata[`SSP_STAT_SMP];
            cke_reg <= pwdata[`SSP_STAT_CKE];
        end
    end

    // read data captured in the setup phase, zero-wait answer
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'h0;
        end else if (psel && !penable) begin
            pslverr_reg <= !mapped(paddr);
            unique case (paddr)
                `SSP_ADDR_STAT: prdata_reg <= {24'h000000, smp_reg,
                    cke_reg, 5'h00, bufFull_reg};
                `SSP_ADDR_CON1: prdata_reg <= {24'h000000, write_collision_reg,
                    ovf_reg, en_reg, ckp_reg, mode_reg};
                // the shifter has no address of its own
                `SSP_ADDR_BUF:  prdata_reg <= {24'h000000, hold_reg};
                default:        prdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = pslverr_reg;

    // pins: clock driven by a master only; data-in never driven
    assign portPinsOwned = en_reg;
    assign sckOut = sckOut_reg;
    assign sckOe  = en_reg && isMaster;
    assign sdoOut = txBit_reg;
    // a deselected slave floats data-out even mid byte
    assign sdoOe  = en_reg && (isMaster || (isSlave && !ssHigh));
    assign portIrqFlag = irq_reg;

    // checks on the behaviour above
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence sqMStart;
        loadOk && isMaster && (mode_reg != ssp_pkg::SSP_M_TIMER_TWO);
    endsequence
    sequence sqMEnd;
        ##[1:600] !isRun;
    endsequence

    AST_RX_TO_BUF: assert property (
        (mDone || (sDone && !bufFull_reg)) |=> bufFull_reg &&
        portIrqFlag && hold_reg == $past(rxByte))
        else $error("received byte not moved to buffer");
    AST_TX_LOAD: assert property (
        loadOk |=> hold_reg == $past(pwdata[7:0]) &&
        sdoOut == $past(pwdata[7]))
        else $error("buffer write did not load both registers");
    AST_SMP_END: assert property (
        (mTick && smp_reg && mSample && nEdge < `SSP_EDGE_LATE) |-> mOut)
        else $error("late sample off the output edge");
    AST_OUT_EDGE: assert property (
        (isRun && !(mTick && mTx)) |=> $stable(sdoOut))
        else $error("data-out changed off its edge");
    AST_BF_CLEAR: assert property (
        (bufRd && !rxDone) |=> !bufFull_reg)
        else $error("buffer read left buffer_full set");
    AST_WRITE_COLLISION: assert property (
        collide |=> write_collision_reg && ($stable(txSh_reg) || $past(mTick || sOut)))
        else $error("collision not flagged");
    AST_OVF: assert property (
        (sDone && bufFull_reg) |=> ovf_reg && $stable(hold_reg))
        else $error("slave overrun not flagged");
    AST_NO_OVF_MASTER: assert property (
        (isMaster && !ovf_reg && !conWr) |=> !ovf_reg)
        else $error("overflow set in master mode");
    AST_PINS_OFF: assert property (
        !en_reg |-> !sckOe && !sdoOe && !portPinsOwned)
        else $error("pins driven while disabled");
    AST_IDLE_LVL: assert property (
        (!isRun && $stable(ckp_reg))[*2] |-> sckOut == ckp_reg)
        else $error("serial clock not at idle level");
    AST_START: assert property (
        (loadOk && isMaster) |=> isRun && edgeCnt_reg == 5'h00)
        else $error("master did not start on write");
    AST_BYTE_ENDS: assert property (
        sqMStart |-> sqMEnd)
        else $error("master byte did not finish");
    AST_SS_RESET: assert property (
        (ssHigh && en_reg) |=> bitCnt_reg == 3'h0 ##0 !sdoOe || !ssHigh)
        else $error("deselect did not reset the port");
    AST_T2_TICK: assert property (
        (isRun && mode_reg == ssp_pkg::SSP_M_TIMER_TWO) |->
        rif.tick == timerTwoPulse)
        else $error("timer_two rate not followed");
endmodule

/* File: verif/ssp_spi_peer.sv */
// Purpose: spi slave peer that answers the port in master mode
// Assumes: clock idles low, data out on trailing edge
// Notes:   sees clock edges through the core clock
module ssp_spi_peer (
    input  wire logic       clk,  // core clock
    input  wire logic       sck,  // serial clock from port
    input  wire logic       sdo,  // port data out
    input  wire logic       load, // preload reply byte
    input  wire logic [7:0] tx,   // reply byte
    output logic            sdi,  // reply bit to port
    output logic      [7:0] rx    // byte taken from port
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       sckD; // last clock level
    logic [7:0] sh;   // reply shifter
    assign sdi = sh[7]; // msb first
    // latch on leading edge, shift on trailing edge
    always @(posedge clk) begin
        sckD <= sck;
        if (load) sh <= tx;
        else if (!sck && sckD) sh <= {sh[6:0], 1'b0};
        if (sck && !sckD) rx <= {rx[6:0], sdo};
    end
endmodule

/* File: verif/ssp_spi_top_tb.sv */
// Purpose: self-checking bench of the serial port, master and slave
// Assumes: zero-wait apb, peer answers as slave
// Notes:   reads push the expected word, a monitor compares
`include "ssp_cfg.svh"
module ssp_spi_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, t2 = 0;
    logic        load = 0;      // peer preload
    logic [7:0]  paddr = 8'h00; // apb address
    logic [7:0]  tx = 8'h00;    // peer reply
    logic [7:0]  rx;            // peer capture
    logic [31:0] pwdata = 32'h0, prdata;
    logic        pready, pslverr, sck, sckOe, sdo, sdoOe, sdi, own;
    logic [32:0] q[$];          // expected read words
    logic [32:0] r;             // last raw read
    logic        slv = 0, ss = 1, msck = 0, msdi = 0, irq; // slave side
    logic [7:0]  sr = 8'h00;    // bytes taken from data-out as master
    logic [1:0]  t2gap = 2'h0;  // cycles since last timer_two pulse
    int          irqs = 0;      // byte events seen
    int fail_count = 0, total_checks = 0;
    always #10 clk = ~clk;
    ssp_spi_top u_dut (.clk(clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sckIn(msck), .sckOut(sck), .sckOe(sckOe),
        .sdoOut(sdo), .sdoOe(sdoOe), .sdiIn(slv ? msdi : sdi),
        .ssInN(ss), .timerTwoPulse(t2), .portIrqFlag(irq),
        .portPinsOwned(own));
    ssp_spi_peer u_peer (.clk(clk), .sck(sck), .sdo(sdo), .load(load),
        .tx(tx), .sdi(sdi), .rx(rx));
    // random timer_two pulses at least five cycles apart, so the
    // synchronised data-in settles between serial clock edges
    always @(posedge clk) begin
        t2 <= !t2 && (t2gap == 2'h3) && ($urandom_range(3) == 0);
        t2gap <= t2 ? 2'h0 : t2gap + {1'b0, t2gap != 2'h3};
    end
    always @(posedge clk) if (irq === 1'b1) irqs++;
    // bench as spi master: leading edge drives data-in, trailing
    // edge takes data-out; 8 clk period, 160 ns
    task sbits(input logic [7:0] d, input int n);
        for (int i = 7; i > 7 - n; i--) begin
            msck <= 1'b1;
            msdi <= d[i];
            repeat (4) @(posedge clk);
            msck <= 1'b0;
            sr = {sr[6:0], sdo};
            repeat (4) @(posedge clk);
        end
    endtask
    task check(input string n, input logic [32:0] s, input logic [32:0] e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("Error %s exp %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer, entered just after a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task rd(input logic [7:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // monitor: oldest note against each checked read
    always @(posedge clk)
        if (psel && penable && pready === 1'b1 && !pwrite && q.size() > 0)
            check("apb read", {pslverr, prdata}, q.pop_front());
    task poll;
        r = 33'h0;
        for (int i = 0; i < 400 && r[0] !== 1'b1; i++)
            apb(1'b0, `SSP_ADDR_STAT, 32'h0);
    endtask
    // master byte with a peer reply, then buffer and flag checks
    task xfer(input logic [7:0] d, input logic [7:0] p);
        load <= 1'b1;
        tx <= p;
        @(posedge clk) load <= 1'b0;
        apb(1'b1, `SSP_ADDR_BUF, {24'h0, d});
        poll;
        rd(`SSP_ADDR_STAT, 33'h41);
        rd(`SSP_ADDR_BUF, {25'h0, p});
        rd(`SSP_ADDR_STAT, 33'h40);
        check("peer rx", {25'h0, rx}, {25'h0, d});
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        #1ms;
        fail_count++;
        test_done;
    end
    initial begin
        void'($urandom(32'h506C));
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(`SSP_ADDR_STAT, 33'h0);
        rd(`SSP_ADDR_CON1, 33'h0);
        rd(8'h0C, {1'b1, 32'h0});
        apb(1'b1, `SSP_ADDR_STAT, 32'hFF);
        rd(`SSP_ADDR_STAT, 33'hC0);
        apb(1'b1, `SSP_ADDR_STAT, 32'h40);
        $display("test registers done");
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, `SSP_ADDR_CON1, 32'h00);
            apb(1'b1, `SSP_ADDR_CON1, 32'h20 | m);
            // clk/4 outruns the data-in synchroniser: reply zeros there
            xfer(8'($urandom), (m == 0) ? 8'h00 : 8'($urandom));
        end
        $display("test rates done");
        apb(1'b1, `SSP_ADDR_BUF, 32'hA5);
        apb(1'b1, `SSP_ADDR_BUF, 32'h5A);
        rd(`SSP_ADDR_CON1, 33'hA3);
        poll;
        check("peer rx", {25'h0, rx}, 33'hA5);
        rd(`SSP_ADDR_BUF, 33'h0);
        $display("test collision done");
        apb(1'b1, `SSP_ADDR_CON1, 32'h00);
        apb(1'b1, `SSP_ADDR_CON1, 32'h32);
        @(posedge clk);
        check("pins", {own, sckOe, sdoOe, sck}, 33'hF);
        apb(1'b1, `SSP_ADDR_CON1, 32'h00);
        @(posedge clk);
        check("pins", {own, sckOe, sdoOe, sck}, 33'h0);
        $display("test pins done");
        slv <= 1'b1;
        apb(1'b1, `SSP_ADDR_STAT, 32'h00);
        apb(1'b1, `SSP_ADDR_CON1, 32'h25);
        apb(1'b1, `SSP_ADDR_BUF, 32'h3C);
        sbits(8'hC3, 8);
        check("slave tx", {25'h0, sr}, 33'h3C);
        rd(`SSP_ADDR_STAT, 33'h01);
        sbits(8'h96, 8);
        rd(`SSP_ADDR_CON1, 33'h65);
        rd(`SSP_ADDR_BUF, 33'hC3);
        rd(`SSP_ADDR_STAT, 33'h00);
        apb(1'b1, `SSP_ADDR_CON1, 32'h00);
        apb(1'b1, `SSP_ADDR_CON1, 32'h24);
        ss <= 1'b0;
        repeat (4) @(posedge clk);
        sbits(8'hFF, 3);
        ss <= 1'b1;
        repeat (4) @(posedge clk);
        check("deselect oe", {32'h0, sdoOe}, 33'h0);
        ss <= 1'b0;
        repeat (4) @(posedge clk);
        sbits(8'h5A, 8);
        rd(`SSP_ADDR_BUF, 33'h5A);
        check("byte events", irqs, 33'h8);
        $display("test slave done");
        test_done;
    end
endmodule
